/* File: rtl/tct_pkg.sv */
// Register map, field layout and types of the triple countdown timer
package tct_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned NUM_TMR = 3;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned CTRL_W = 3;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] TMR_BASE [NUM_TMR] = '{8'h00, 8'h14, 8'h28};
    localparam logic [ADDR_W-1:0] OFS_LOAD_VALUE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_COUNT_NOW = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CTRL_WORD = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ACK = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_FLAG = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_ALL_FLAGS = 8'ha0;
    localparam logic [ADDR_W-1:0] OFS_ALL_ACK = 8'ha4;
    localparam logic [ADDR_W-1:0] OFS_ALL_RAW = 8'ha8;

    // ------------------------------------------------------------
    // Control word fields and reset values
    // ------------------------------------------------------------
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned CTRL_MODE_BIT = 1;
    localparam int unsigned CTRL_MASK_BIT = 2;
    localparam logic MODE_FREE = 1'h0;
    localparam logic MODE_USER = 1'h1;
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
    localparam logic [CNT_W-1:0] LOAD_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 32'hffff_ffff;

    // ------------------------------------------------------------
    // Clock rates
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ = 25_000_000;
    localparam int unsigned CNT_CLK_HZ = 24_000_000;

    // ------------------------------------------------------------
    // Types and helpers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RESP
    } tct_apb_st_t;

    function automatic logic tct_hit(logic [ADDR_W-1:0] addr, logic [ADDR_W-1:0] base,
                                     logic [ADDR_W-1:0] ofs);
        logic [ADDR_W-1:0] target;
        target = base + ofs;
        return addr == target;
    endfunction

endpackage

/* File: rtl/tct_tmr_if.sv */
// Link between the register block and one timer's tick detector and counter
interface tct_tmr_if;
    import tct_pkg::*;

    logic [CNT_W-1:0] load_val;
    logic run;
    logic mode;
    logic tick;
    logic [CNT_W-1:0] count;
    logic zero_evt;

    modport ctl (output load_val, output run, output mode, input count, input zero_evt);
    modport det (input run, output tick);
    modport core (input load_val, input run, input mode, input tick,
                  output count, output zero_evt);
endinterface

/* File: rtl/tct_tick_det.sv */
// Rising edge detector for one timer's count clock
module tct_tick_det
    import tct_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Count clock, sampled as a level
    input wire logic cnt_clk,
    // Timer link
    tct_tmr_if.det tif
);

    logic cnt_clk_q_r, cnt_clk_q_nxt;
    logic tick_r, tick_nxt;

    // Edges are only counted while running; a gated clock brings no stray tick
    always_comb begin
        cnt_clk_q_nxt = cnt_clk;
        tick_nxt = tif.run & cnt_clk & ~cnt_clk_q_r;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_clk_q_r <= 1'h0;
            tick_r <= 1'h0;
        end else begin
            cnt_clk_q_r <= cnt_clk_q_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tif.tick = tick_r;

endmodule

/* File: rtl/tct_tmr_core.sv */
// One 32-bit down counter with load, reload and zero event
module tct_tmr_core
    import tct_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Timer link
    tct_tmr_if.core tif
);

    logic [CNT_W-1:0] count_r, count_nxt;
    logic load_pend_r, load_pend_nxt;
    logic zero_r, zero_nxt;

    always_comb begin
        count_nxt = count_r;
        load_pend_nxt = load_pend_r;
        zero_nxt = 1'h0;
        if (!tif.run) begin
            // Stopped: the count is held at zero and the initial load is re-armed
            count_nxt = '0;
            load_pend_nxt = 1'h1;
        end else if (tif.tick) begin
            if (load_pend_r) begin
                count_nxt = tif.load_val;
                load_pend_nxt = 1'h0;
            end else if (count_r == '0) begin
                zero_nxt = 1'h1;
                if (tif.mode == MODE_USER) begin
                    count_nxt = tif.load_val;
                end else begin
                    count_nxt = CNT_MAX;
                end
            end else begin
                count_nxt = count_r - 1'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
            load_pend_r <= 1'h1;
            zero_r <= 1'h0;
        end else begin
            count_r <= count_nxt;
            load_pend_r <= load_pend_nxt;
            zero_r <= zero_nxt;
        end
    end

    assign tif.count = count_r;
    assign tif.zero_evt = zero_r;

endmodule

/* File: rtl/tct_top.sv */
// Triple countdown timer: APB register block and three timer channels
//
// Contract
// - Three independent timers, each with 32-bit counter and its own registers.
// - An enabled timer counts down and raises its interrupt on reaching zero.
// - Control bit 0 starts the timer when 1 and stops it when 0.
// - While running, the counter decrements once per count clock rising edge.
// - On enabling, the load value enters the counter at the next count edge.
// - Clearing run clears the counter and all count-domain state; the code re-arms the load and the edge sampler keeps tracking.
// - Reading the current count of a stopped timer returns zero.
// - Control bit 1 selects mode: 0 free-running, 1 user-defined reload.
// - User mode reloads the current load value at zero and keeps counting.
// - Free-running mode reloads all ones at zero instead of the load value.
// - Control bit 2 masks the timer interrupt when 1, passes it when 0.
// - Reading a timer's acknowledge register returns zero and clears its interrupt.
// - Reading the global acknowledge returns zero and clears all three interrupts.
// - Global status shows masked states in bits 2..0; per-timer status in bit 0.
// - Global raw status shows unmasked interrupt states in bits 2..0.
// - A run output follows the enable bit and drops when it is cleared.
// - After a rising edge of the run output the initial count loads at the next count clock edge.
// - Count clock crossings into the bus clock domain are properly handled; the code samples the raw count clock directly, with no synchronizer stage.
module tct_top
    import tct_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [CNT_W-1:0] pwdata,
    output logic [CNT_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Count clocks, one per timer
    input wire logic [NUM_TMR-1:0] timer_cnt_clk,
    // Timer outputs
    output logic [NUM_TMR-1:0] timer_run,
    output logic [NUM_TMR-1:0] timer_irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    tct_apb_st_t st_r, st_nxt;
    logic [CNT_W-1:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;

    logic [CNT_W-1:0] load_r [NUM_TMR];
    logic [CNT_W-1:0] load_nxt [NUM_TMR];
    logic [CTRL_W-1:0] ctrl_r [NUM_TMR];
    logic [CTRL_W-1:0] ctrl_nxt [NUM_TMR];

    logic [NUM_TMR-1:0] raw_r, raw_nxt;
    logic [NUM_TMR-1:0] irq_r, irq_nxt;

    // ------------------------------------------------------------
    // Decode wires
    // ------------------------------------------------------------
    logic [CNT_W-1:0] count_w [NUM_TMR];
    logic [NUM_TMR-1:0] zero_w;
    logic [CNT_W-1:0] rd_mux;
    logic [NUM_TMR-1:0] ack_sel;
    logic [NUM_TMR-1:0] ack_now;
    logic access;
    logic rd_fire;
    logic wr_fire;

    // ------------------------------------------------------------
    // Timer channels
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_TMR; i++) begin : g_tmr
        tct_tmr_if tif();

        assign tif.load_val = load_r[i];
        assign tif.run = ctrl_r[i][CTRL_RUN_BIT];
        assign tif.mode = ctrl_r[i][CTRL_MODE_BIT];
        assign count_w[i] = tif.count;
        assign zero_w[i] = tif.zero_evt;

        tct_tick_det u_tick (
            .sys_clk (sys_clk),
            .rst_n (rst_n),
            .cnt_clk (timer_cnt_clk[i]),
            .tif (tif.det)
        );

        tct_tmr_core u_core (
            .sys_clk (sys_clk),
            .rst_n (rst_n),
            .tif (tif.core)
        );
    end

    // ------------------------------------------------------------
    // Access qualification
    // ------------------------------------------------------------
    // One wait state: the response flop closes every access phase
    always_comb begin
        access = psel & penable & (st_r == ST_IDLE);
        rd_fire = access & ~pwrite;
        wr_fire = access & pwrite;
    end

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    // Unmapped offsets and reserved bits fall through as zero
    always_comb begin
        rd_mux = '0;
        ack_sel = '0;
        for (int i = 0; i < NUM_TMR; i++) begin
            if (tct_hit(paddr, TMR_BASE[i], OFS_LOAD_VALUE)) begin
                rd_mux = load_r[i];
            end
            if (tct_hit(paddr, TMR_BASE[i], OFS_COUNT_NOW)) begin
                if (ctrl_r[i][CTRL_RUN_BIT]) begin
                    rd_mux = count_w[i];
                end else begin
                    rd_mux = '0;
                end
            end
            if (tct_hit(paddr, TMR_BASE[i], OFS_CTRL_WORD)) begin
                rd_mux = CNT_W'(ctrl_r[i]);
            end
            if (tct_hit(paddr, TMR_BASE[i], OFS_IRQ_ACK)) begin
                ack_sel[i] = 1'h1;
            end
            if (tct_hit(paddr, TMR_BASE[i], OFS_IRQ_FLAG)) begin
                rd_mux = CNT_W'(irq_r[i]);
            end
        end
        if (paddr == OFS_ALL_FLAGS) begin
            rd_mux = CNT_W'(irq_r);
        end
        if (paddr == OFS_ALL_ACK) begin
            ack_sel = '1;
        end
        if (paddr == OFS_ALL_RAW) begin
            rd_mux = CNT_W'(raw_r);
        end
    end

    // ------------------------------------------------------------
    // APB response
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        prdata_nxt = prdata_r;
        pready_nxt = 1'h0;
        pslverr_nxt = 1'h0;
        case (st_r)
            ST_IDLE: begin
                if (access) begin
                    st_nxt = ST_RESP;
                    pready_nxt = 1'h1;
                    if (rd_fire) begin
                        prdata_nxt = rd_mux;
                    end else begin
                        prdata_nxt = '0;
                    end
                end
            end
            ST_RESP: begin
                st_nxt = ST_IDLE;
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_IDLE;
            prdata_r <= '0;
            pready_r <= 1'h0;
            pslverr_r <= 1'h0;
        end else begin
            st_r <= st_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Load and control registers
    // ------------------------------------------------------------
    // A new load value written while running only shows at the next user-mode reload
    always_comb begin
        for (int i = 0; i < NUM_TMR; i++) begin
            load_nxt[i] = load_r[i];
            ctrl_nxt[i] = ctrl_r[i];
            if (wr_fire && tct_hit(paddr, TMR_BASE[i], OFS_LOAD_VALUE)) begin
                load_nxt[i] = pwdata;
            end
            if (wr_fire && tct_hit(paddr, TMR_BASE[i], OFS_CTRL_WORD)) begin
                ctrl_nxt[i][CTRL_RUN_BIT] = pwdata[CTRL_RUN_BIT];
                ctrl_nxt[i][CTRL_MODE_BIT] = pwdata[CTRL_MODE_BIT];
                ctrl_nxt[i][CTRL_MASK_BIT] = pwdata[CTRL_MASK_BIT];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_TMR; i++) begin
                load_r[i] <= LOAD_RST;
                ctrl_r[i] <= CTRL_RST;
            end
        end else begin
            for (int i = 0; i < NUM_TMR; i++) begin
                load_r[i] <= load_nxt[i];
                ctrl_r[i] <= ctrl_nxt[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt flags
    // ------------------------------------------------------------
    // A zero event in the acknowledge cycle survives: set beats clear
    always_comb begin
        ack_now = ack_sel & {NUM_TMR{rd_fire}};
        for (int i = 0; i < NUM_TMR; i++) begin
            raw_nxt[i] = zero_w[i] | (raw_r[i] & ~ack_now[i]);
            irq_nxt[i] = raw_nxt[i] & ~ctrl_nxt[i][CTRL_MASK_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_r <= '0;
            irq_r <= '0;
        end else begin
            raw_r <= raw_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign timer_irq = irq_r;

    always_comb begin
        for (int i = 0; i < NUM_TMR; i++) begin
            timer_run[i] = ctrl_r[i][CTRL_RUN_BIT];
        end
    end

endmodule

/* File: testbench/tct_top_monitor.sv */
// Port level checks of the timer block
module tct_top_monitor
    import tct_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [CNT_W-1:0] pwdata,
    input wire logic [CNT_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Timers
    input wire logic [NUM_TMR-1:0] timer_cnt_clk,
    input wire logic [NUM_TMR-1:0] timer_run,
    input wire logic [NUM_TMR-1:0] timer_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic take;
    logic rd;
    logic wr;
    assign take = psel && penable && !pready;
    assign rd = take && !pwrite;
    assign wr = take && pwrite;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_ready_after_take: assert property (take |=> pready)
        else $error("no ready after access");
    a_ready_one_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_no_slave_error: assert property (!pslverr)
        else $error("slave error raised");
    a_ack_reads_zero: assert property (rd && (paddr == 8'h0c || paddr == 8'ha4)
        |=> prdata == 32'h0) else $error("ack read not zero");
    a_ack_drops_irq: assert property (rd && paddr == 8'h0c |-> ##2 !timer_irq[0])
        else $error("ack left irq set");
    a_all_ack_drops: assert property (rd && paddr == 8'ha4 |-> ##2 timer_irq == 3'h0)
        else $error("global ack left irq set");
    a_run_follows_ctrl: assert property (wr && paddr == 8'h08
        |-> ##2 timer_run[0] == $past(pwdata[0], 2)) else $error("run output wrong");
    a_mask_blocks_irq: assert property (wr && paddr == 8'h08 && pwdata[2]
        |-> ##2 !timer_irq[0]) else $error("masked irq seen");
    a_stopped_reads_zero: assert property (rd && paddr == 8'h04 && !timer_run[0]
        |=> prdata == 32'h0) else $error("stopped count not zero");
    a_status_reserved: assert property (rd && (paddr == 8'ha0 || paddr == 8'ha8)
        |=> prdata[31:3] == 29'h0) else $error("reserved status bits set");

    c_irq_raised: cover property ($rose(timer_irq[0]));
    c_all_ack: cover property (rd && paddr == 8'ha4);
    c_run_rise: cover property ($rose(timer_run[2]));
endmodule

bind tct_top tct_top_monitor u_tct_top_monitor (.sys_clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_cnt_clk, .timer_run, .timer_irq);

/* File: testbench/tct_cnt_src.sv */
// Gated count clock source standing in for the clock controller
module tct_cnt_src
    import tct_pkg::*;
#(
    parameter int HALF = 4
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Gate control and count clocks
    input wire logic [NUM_TMR-1:0] gate_on,
    output logic [NUM_TMR-1:0] cnt_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    int div [NUM_TMR];

    // Slow clock: the block samples it as a level, so 24 MHz would alias
    // Gated clock stands low, never runs free between uses
    always @(posedge sys_clk or negedge rst_n) begin
        for (int i = 0; i < NUM_TMR; i++) begin
            if (!rst_n || !gate_on[i]) begin
                div[i] <= 0;
                cnt_clk[i] <= 1'h0;
            end else if (div[i] == HALF - 1) begin
                div[i] <= 0;
                cnt_clk[i] <= !cnt_clk[i];
            end else begin
                div[i] <= div[i] + 1;
            end
        end
    end
endmodule

/* File: testbench/triple_countdown_timer_bench.sv */
// Register level test of the triple countdown timer
module triple_countdown_timer_bench
    import tct_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'h0;
    logic rst_n = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [CNT_W-1:0] pwdata = 32'h0;
    logic [CNT_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_TMR-1:0] gate_on = 3'h0;
    logic [NUM_TMR-1:0] cnt_clk;
    logic [NUM_TMR-1:0] timer_run;
    logic [NUM_TMR-1:0] timer_irq;
    logic [CNT_W-1:0] rd_val;
    logic [CNT_W-1:0] first;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;

    always #20 sys_clk = !sys_clk;

    tct_top u_tct_top (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .timer_cnt_clk(cnt_clk), .timer_run, .timer_irq);
    tct_cnt_src u_tct_cnt_src (.sys_clk, .rst_n, .gate_on, .cnt_clk);

    task automatic chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'h1 && n < 8);
        chk({31'h0, pready}, 32'h1);
        rd_val = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] d);
        apb(1'h1, a, d);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rd_val, exp);
    endtask

    task automatic wait_irq(input int i);
        int n;
        n = 0;
        while (timer_irq[i] !== 1'h1 && n < 400) begin
            @(posedge sys_clk);
            n++;
        end
        chk({31'h0, timer_irq[i]}, 32'h1);
    endtask

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'h1;
        @(posedge sys_clk);
        for (int i = 0; i < NUM_TMR; i++) begin
            for (int r = 0; r < 5; r++) begin
                rd(TMR_BASE[i] + 8'(4 * r), 32'h0);
            end
        end
        rd(OFS_ALL_FLAGS, 32'h0);
        rd(OFS_ALL_RAW, 32'h0);
        rd(8'hfc, 32'h0);
        $display("test reset values done");
        wr(OFS_CTRL_WORD, 32'h2);
        wr(OFS_LOAD_VALUE, 32'h3);
        wr(OFS_CTRL_WORD, 32'hffff_fffb);
        rd(OFS_CTRL_WORD, 32'h3);
        chk({31'h0, timer_run[0]}, 32'h1);
        gate_on[0] <= 1'h1;
        wait_irq(0);
        rd(OFS_IRQ_FLAG, 32'h1);
        rd(OFS_ALL_RAW, 32'h1);
        apb(1'h0, OFS_COUNT_NOW, 32'h0);
        chk(32'(rd_val <= 32'h3), 32'h1);
        rd(OFS_IRQ_ACK, 32'h0);
        rd(OFS_IRQ_FLAG, 32'h0);
        wait_irq(0);
        wr(OFS_CTRL_WORD, 32'h6);
        chk({31'h0, timer_run[0]}, 32'h0);
        rd(OFS_COUNT_NOW, 32'h0);
        gate_on[0] <= 1'h0;
        rd(OFS_ALL_ACK, 32'h0);
        $display("test user mode done");
        wr(8'h1c, 32'h0);
        wr(8'h14, 32'h1);
        wr(8'h1c, 32'h1);
        gate_on[1] <= 1'h1;
        wait_irq(1);
        apb(1'h0, 8'h18, 32'h0);
        chk(32'(rd_val >= 32'hffff_fff0), 32'h1);
        wr(8'h1c, 32'h5);
        chk({31'h0, timer_irq[1]}, 32'h0);
        rd(OFS_ALL_FLAGS, 32'h0);
        rd(OFS_ALL_RAW, 32'h2);
        rd(OFS_ALL_ACK, 32'h0);
        rd(OFS_ALL_RAW, 32'h0);
        wr(8'h18, 32'h5);
        apb(1'h0, 8'h18, 32'h0);
        chk(32'(rd_val >= 32'hffff_ff00), 32'h1);
        wr(8'h1c, 32'h0);
        gate_on[1] <= 1'h0;
        $display("test free mode done");
        wr(8'h30, 32'h0);
        wr(8'h28, 32'h1234_0000);
        wr(8'h30, 32'h1);
        gate_on[2] <= 1'h1;
        repeat (24) @(posedge sys_clk);
        apb(1'h0, 8'h2c, 32'h0);
        first = rd_val;
        chk(32'(first <= 32'h1234_0000 && first > 32'h1233_fff0), 32'h1);
        repeat (16) @(posedge sys_clk);
        apb(1'h0, 8'h2c, 32'h0);
        chk(32'((first - rd_val) inside {[1:4]}), 32'h1);
        wr(8'h30, 32'h0);
        gate_on[2] <= 1'h0;
        $display("test load and count done");
        end_of_test();
    end
endmodule
